// *** hw/posind_regs.svh ***
// Position indication constants: defaults, limits and counts
`ifndef POSIND_REGS_SVH
`define POSIND_REGS_SVH

// ==========================================================
// Widths and counts
`define POSIND_POS_W 32
`define POSIND_AREA_COUNT 8

// ==========================================================
// Revolution marker width, in tenths of a degree
`define POSIND_MARK_W_DEF 11'h012
`define POSIND_MARK_W_MAX 11'h708
`define POSIND_DEG10_PER_REV 43'h00000000e10

// ==========================================================
// Wrap zero pulse width in steps and interval count
`define POSIND_WZ_WIDTH_DEF 14'h000a
`define POSIND_WZ_WIDTH_MAX 14'h2710
`define POSIND_WZ_DIV_DEF 29'h00000001
`define POSIND_WZ_DIV_MAX 29'h1fffffff

`endif

// *** hw/posind_pkg.sv ***
// Types and shared arithmetic for the position indication outputs
package posind_pkg;

  // ==========================================================
  // Modes
  typedef enum logic {POSIND_SRC_FB, POSIND_SRC_CMD} posind_src_t;
  typedef enum logic {POSIND_AREA_ABS, POSIND_AREA_OFS} posind_amode_t;

  // ==========================================================
  // Module state
  typedef struct packed {
    logic [31:0] prev;
    logic [31:0] wpos;
    logic [31:0] ipos;
    logic zero;
    logic ovf;
  } posind_wrap_st_t;

  typedef struct packed {
    logic flag;
  } posind_area_st_t;

  typedef struct packed {
    logic [31:0] fb_prev;
    logic [31:0] phase;
    logic [31:0] mark_steps;
    logic marker;
    logic fw;
    logic rv;
    logic coord_valid;
    logic home_invalid;
    logic home_set;
    logic preset_seen;
    logic preset_stored;
    logic factory_home;
    logic strap_s1;
    logic strap_s2;
    logic [1:0] cap_wait;
  } posind_top_st_t;

  // ==========================================================
  // Modular step: {wrapped, new position} inside [0, r), r >= 1
  // Assumes one step never moves more than r
  function automatic logic [32:0] posind_wrap_step(input logic [31:0] p,
    input logic [31:0] d, input logic [31:0] r);
    logic [33:0] s;
    logic [33:0] rr;
    rr = {2'b00, r};
    s = {2'b00, p} + {{2{d[31]}}, d};
    if (s[33])
      return {1'b1, 32'(s + rr)};
    if (s >= rr)
      return {1'b1, 32'(s - rr)};
    return {1'b0, s[31:0]};
  endfunction

endpackage

// *** hw/posind_pos_if.sv ***
// Position bus from the top to its comparators
`timescale 1ns/1ns
`default_nettype none

interface posind_pos_if (
  input wire logic clk,
  input wire logic rst
);
  // Feedback, command and target positions, same clock
  logic [31:0] fb;
  logic [31:0] cmd;
  logic [31:0] target;

  // Driving side and listening side
  modport src (input clk, input rst, output fb, output cmd, output target);
  modport snk (input clk, input rst, input fb, input cmd, input target);
endinterface

`default_nettype wire

// *** hw/posind_area.sv ***
// One area window comparator with a registered flag
`timescale 1ns/1ns
`default_nettype none

module posind_area (
  // Positions, clock and reset
  posind_pos_if.snk pos,
  // Window settings
  input wire logic [31:0] pos_bound_in,
  input wire logic [31:0] neg_bound_in,
  input wire posind_pkg::posind_amode_t mode_in,
  input wire posind_pkg::posind_src_t src_in,
  // Flag
  output logic flag_out
);
  // Sign extension to 34 bits so offsets never overflow
  function automatic logic signed [33:0] sx(input logic [31:0] v);
    return signed'({{2{v[31]}}, v});
  endfunction

  posind_pkg::posind_area_st_t st_q;
  posind_pkg::posind_area_st_t st_d;
  logic signed [33:0] x, p, n, ctr;

  // ==========================================================
  // Window judgement
  always_comb
  begin
    st_d = st_q;
    x = sx((src_in == posind_pkg::POSIND_SRC_CMD) ? pos.cmd : pos.fb); // RQ11
    p = sx(pos_bound_in); // RQ9
    n = sx(neg_bound_in);
    ctr = sx(pos.target) + p;
    if (mode_in == posind_pkg::POSIND_AREA_OFS)
      st_d.flag = (x >= ctr - n) && (x <= ctr + n); // RQ10 RQ15
    else if (p > n)
      st_d.flag = (x >= n) && (x <= p); // RQ12
    else if (p < n)
      st_d.flag = (x <= p) || (x >= n); // RQ13
    else
      st_d.flag = (x == p); // RQ14
  end

  // Flag follows the position every cycle, moving or not
  always_ff @(posedge pos.clk)
  begin
    if (pos.rst)
      st_q <= '0;
    else
      st_q <= st_d; // RQ8
  end

  assign flag_out = st_q.flag;
endmodule

`default_nettype wire

// *** hw/posind_wrap.sv ***
// Wrap range tracker: zero pulses per interval and overflow toggle
`timescale 1ns/1ns
`default_nettype none
`include "posind_regs.svh"

module posind_wrap (
  // Positions, clock and reset
  posind_pos_if.snk pos,
  // Settings
  input wire logic en_in,
  input wire logic [31:0] range_in,
  input wire logic [28:0] div_in,
  input wire logic [13:0] width_in,
  input wire posind_pkg::posind_src_t src_in,
  // Outputs
  output logic zero_out,
  output logic ovf_out
);
  posind_pkg::posind_wrap_st_t st_q;
  posind_pkg::posind_wrap_st_t st_d;
  logic [31:0] x, rng, ivl, delta;
  logic [28:0] divc;
  logic [13:0] wid;
  logic [32:0] ws, is;

  // ==========================================================
  // Tracking of wrap and interval phases
  always_comb
  begin
    st_d = st_q;
    x = (src_in == posind_pkg::POSIND_SRC_CMD) ? pos.cmd : pos.fb; // RQ7
    rng = (range_in == 32'h0) ? 32'h1 : range_in;
    divc = (div_in == 29'h0) ? `POSIND_WZ_DIV_DEF : div_in;
    ivl = rng / {3'h0, divc}; // RQ5
    if (ivl == 32'h0)
      ivl = 32'h1;
    wid = (width_in == 14'h0) ? 14'h0001 : width_in;
    if (wid > `POSIND_WZ_WIDTH_MAX)
      wid = `POSIND_WZ_WIDTH_MAX;
    delta = x - st_q.prev;
    ws = posind_pkg::posind_wrap_step(st_q.wpos, delta, rng);
    is = posind_pkg::posind_wrap_step(st_q.ipos, delta, ivl);
    st_d.prev = x;
    st_d.wpos = ws[31:0];
    st_d.ipos = is[31:0];
    // Pulse from each interval boundary for the set width
    st_d.zero = en_in && (is[31:0] < {18'h0, wid}); // RQ4 RQ6
    // Level flips on each pass out of range
    if (en_in && ws[32])
      st_d.ovf = ~st_q.ovf; // RQ17
  end

  always_ff @(posedge pos.clk)
  begin
    if (pos.rst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign zero_out = st_q.zero;
  assign ovf_out = st_q.ovf;
endmodule

`default_nettype wire

// *** hw/posind_top.sv ***
// Position indication outputs: marker, areas, wrap, limits, coordinate flags
//
// Functional notes
// RQ1 - Marker fires every revolution from preset reference
// RQ2 - Marker width 1 to 1800 tenths, default 18
// RQ3 - Controller keeps marker pulse at least 1 ms
// RQ4 - Wrap zero asserts at home when enabled
// RQ5 - Wrap range split into programmable equal intervals
// RQ6 - Wrap zero width 1 to 10000 steps
// RQ7 - Wrap zero source feedback or command position
// RQ8 - Eight area flags, asserted even when stopped
// RQ9 - Two signed 32-bit bounds per area
// RQ10 - Area mode absolute or offset/width from target
// RQ11 - Area judges feedback or command position
// RQ12 - Positive above negative: inclusive between both bounds
// RQ13 - Positive below negative: outside band, inclusive ends
// RQ14 - Equal bounds: exact match only
// RQ15 - Offset mode: centre target plus offset, inclusive
// RQ16 - Soft limit flags when enabled and exceeded
// RQ17 - Wrap overflow toggles level on each overrun
// RQ18 - Coordinates valid once coordinates are established
// RQ19 - Nonzero preset: resolution change flags home invalid
// RQ20 - Zero preset: resolution change re-establishes coordinates
// RQ21 - Controller re-homes after home invalid shows
// RQ22 - Preset stored after preset saved in sensor
// RQ23 - Factory home flag set on delivered units
`timescale 1ns/1ns
`default_nettype none
`include "posind_regs.svh"

module posind_top #(
  parameter int AREA_COUNT = `POSIND_AREA_COUNT
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  // Positions from the control loop
  input wire logic [31:0] FB_POS_IN,
  input wire logic [31:0] CMD_POS_IN,
  input wire logic [31:0] TARGET_POS_IN,
  input wire logic [31:0] RES_STEPS_IN,
  // Revolution marker
  input wire logic REVOLUTION_MARKER_PRESET_CMD_IN,
  input wire logic [10:0] MARKER_WIDTH_IN,
  // Wrap range
  input wire logic WRAP_EN_IN,
  input wire logic [31:0] WRAP_RANGE_IN,
  input wire logic [28:0] WRAP_ZERO_DIV_IN,
  input wire logic [13:0] WRAP_ZERO_WIDTH_IN,
  input wire logic WRAP_ZERO_SRC_IN,
  // Area windows, index 0 is the first flag
  input wire logic [AREA_COUNT-1:0][31:0] AREA_POS_BOUND_IN,
  input wire logic [AREA_COUNT-1:0][31:0] AREA_NEG_BOUND_IN,
  input wire logic [AREA_COUNT-1:0] AREA_MODE_IN,
  input wire logic [AREA_COUNT-1:0] AREA_SRC_IN,
  // Software limits
  input wire logic SOFT_OT_EN_IN,
  input wire logic [31:0] FWD_SOFT_LIMIT_IN,
  input wire logic [31:0] REV_SOFT_LIMIT_IN,
  // Coordinate events, one-cycle pulses
  input wire logic PRESET_DONE_IN,
  input wire logic HOMING_DONE_IN,
  input wire logic RES_CHANGE_IN,
  input wire logic SENSOR_SAVED_IN,
  input wire logic [31:0] PRESET_POS_IN,
  // Strap pin, asynchronous
  input wire logic FACTORY_HOME_STRAP_IN,
  // Position outputs
  output logic REVOLUTION_MARKER_OUT,
  output logic WRAP_ZERO_PULSE_OUT,
  output logic WRAP_OVERFLOW_TOGGLE_OUT,
  output logic [AREA_COUNT-1:0] AREA_FLAG_OUT,
  output logic FORWARD_SOFT_LIMIT_FLAG_OUT,
  output logic REVERSE_SOFT_LIMIT_FLAG_OUT,
  // Coordinate outputs
  output logic COORDINATES_VALID_FLAG_OUT,
  output logic HOME_INVALID_FLAG_OUT,
  output logic PRESET_STORED_FLAG_OUT,
  output logic FACTORY_HOME_FLAG_OUT
);

  // ==========================================================
  // Elaboration checks
  if (AREA_COUNT < 1 || AREA_COUNT > `POSIND_AREA_COUNT)
  begin : g_bad_count
    $error("AREA_COUNT must lie between 1 and 8");
  end

  // ==========================================================
  // Marker width in steps
  // Width in tenths of a degree scaled by steps per turn
  // A zero width or resolution is lifted to one so the pulse never vanishes
  function automatic logic [31:0] posind_mark_steps(input logic [10:0] w,
    input logic [31:0] res);
    logic [10:0] wc;
    logic [42:0] prod;
    logic [42:0] q;
    wc = w;
    if (wc == 11'h000)
      wc = 11'h001;
    if (wc > `POSIND_MARK_W_MAX)
      wc = `POSIND_MARK_W_MAX;
    prod = 43'(wc) * 43'(res);
    q = prod / `POSIND_DEG10_PER_REV;
    if (q == 43'h0)
      return 32'h1;
    return q[31:0];
  endfunction

  // ==========================================================
  // State and reset value
  localparam posind_pkg::posind_top_st_t ST_RST = '0;

  // Registered state of the top, apart from the area and wrap instances
  posind_pkg::posind_top_st_t st_q;
  // Next state
  posind_pkg::posind_top_st_t st_d;
  // Resolution with zero lifted to one
  logic [31:0] res_c;
  // Phase step result
  logic [32:0] ph_step;
  // Home re-establishing events
  logic home_ev;
  // Resolution change that breaks the home
  logic inval_ev;
  // Resolution change that re-zeroes by itself
  logic auto_ev;

  // ==========================================================
  // Shared position bus to the comparators
  posind_pos_if pos_bus (
    .clk(CLK_IN),
    .rst(SYS_RST_IN)
  );

  // Positions are from this clock domain, no sync
  assign pos_bus.fb = FB_POS_IN;
  assign pos_bus.cmd = CMD_POS_IN;
  assign pos_bus.target = TARGET_POS_IN;

  // ==========================================================
  // Area windows
  for (genvar g = 0; g < AREA_COUNT; g++)
  begin : g_area
    posind_area u_area (
      .pos(pos_bus),
      .pos_bound_in(AREA_POS_BOUND_IN[g]),
      .neg_bound_in(AREA_NEG_BOUND_IN[g]),
      .mode_in(posind_pkg::posind_amode_t'(AREA_MODE_IN[g])),
      .src_in(posind_pkg::posind_src_t'(AREA_SRC_IN[g])),
      .flag_out(AREA_FLAG_OUT[g])
    );
  end

  // ==========================================================
  // Wrap range zero pulse and overflow toggle
  posind_wrap u_wrap (
    .pos(pos_bus),
    .en_in(WRAP_EN_IN),
    .range_in(WRAP_RANGE_IN),
    .div_in(WRAP_ZERO_DIV_IN),
    .width_in(WRAP_ZERO_WIDTH_IN),
    .src_in(posind_pkg::posind_src_t'(WRAP_ZERO_SRC_IN)),
    .zero_out(WRAP_ZERO_PULSE_OUT),
    .ovf_out(WRAP_OVERFLOW_TOGGLE_OUT)
  );

  // ==========================================================
  // Event decode
  always_comb
  begin
    // Preset or homing both set a fresh home
    home_ev = PRESET_DONE_IN || HOMING_DONE_IN;
    // Home breaks only if set and the preset value is nonzero
    inval_ev = RES_CHANGE_IN && st_q.home_set && (PRESET_POS_IN != 32'h0); // RQ19
    // With a zero preset the driver re-zeroes by itself
    auto_ev = RES_CHANGE_IN && (PRESET_POS_IN == 32'h0); // RQ20
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    st_d = st_q;

    // Strap pin passes two stages before anything reads it
    st_d.strap_s1 = FACTORY_HOME_STRAP_IN;
    st_d.strap_s2 = st_q.strap_s1;

    // Revolution marker
    // Phase is feedback modulo one turn; moves per cycle
    // must stay under one turn, true at any real speed
    res_c = (RES_STEPS_IN == 32'h0) ? 32'h1 : RES_STEPS_IN;
    st_d.mark_steps = posind_mark_steps(MARKER_WIDTH_IN, res_c); // RQ2
    ph_step = posind_pkg::posind_wrap_step(st_q.phase, FB_POS_IN - st_q.fb_prev, res_c);
    st_d.fb_prev = FB_POS_IN;
    if (REVOLUTION_MARKER_PRESET_CMD_IN)
    begin
      // Present position becomes the zero of the turn
      st_d.phase = 32'h0; // RQ1
    end
    else
    begin
      // Keep counting from the last reference
      st_d.phase = ph_step[31:0]; // RQ1
    end
    // Marker high while the phase is inside the width past zero
    st_d.marker = st_d.phase < st_q.mark_steps; // RQ1 RQ2

    // Software limits
    // Judged on command position only; off when overtravel is disabled
    st_d.fw = SOFT_OT_EN_IN && ($signed(CMD_POS_IN) > $signed(FWD_SOFT_LIMIT_IN)); // RQ16
    st_d.rv = SOFT_OT_EN_IN && ($signed(CMD_POS_IN) < $signed(REV_SOFT_LIMIT_IN)); // RQ16

    // Home bookkeeping
    if (home_ev)
      st_d.home_set = 1'b1;
    if (PRESET_DONE_IN)
      st_d.preset_seen = 1'b1;

    // Home invalid: a new home clears it, but a break in the same cycle wins
    if (inval_ev)
      st_d.home_invalid = 1'b1; // RQ19
    else if (home_ev)
      st_d.home_invalid = 1'b0;

    // Coordinates valid: set by a home, by auto re-zero or by factory
    // home; a break drops it so it agrees with home invalid
    if (inval_ev)
      st_d.coord_valid = 1'b0;
    else if (home_ev || auto_ev)
      st_d.coord_valid = 1'b1; // RQ18 RQ20

    // Preset stored: needs a preset, before or with the sensor save
    if (SENSOR_SAVED_IN && (st_q.preset_seen || PRESET_DONE_IN))
      st_d.preset_stored = 1'b1; // RQ22
    else if (inval_ev)
      st_d.preset_stored = 1'b0;

    // Factory home strap
    // Caught once, when the sync stages fill after reset
    if (st_q.cap_wait != 2'h3)
      st_d.cap_wait = st_q.cap_wait + 2'h1;
    if (st_q.cap_wait == 2'h2)
    begin
      st_d.factory_home = st_q.strap_s2; // RQ23
      // A factory home means coordinates hold from the start
      if (st_q.strap_s2 && !inval_ev)
        st_d.coord_valid = 1'b1; // RQ18
      if (st_q.strap_s2)
        st_d.home_set = 1'b1;
    end
  end

  // ==========================================================
  // State register
  // Synchronous reset to constants only; the strap is caught later
  always_ff @(posedge CLK_IN)
  begin
    if (SYS_RST_IN)
      st_q <= ST_RST;
    else
      st_q <= st_d;
  end

  // ==========================================================
  // Outputs, all from flip-flops
  assign REVOLUTION_MARKER_OUT = st_q.marker;
  assign FORWARD_SOFT_LIMIT_FLAG_OUT = st_q.fw;
  assign REVERSE_SOFT_LIMIT_FLAG_OUT = st_q.rv;
  assign COORDINATES_VALID_FLAG_OUT = st_q.coord_valid;
  assign HOME_INVALID_FLAG_OUT = st_q.home_invalid;
  assign PRESET_STORED_FLAG_OUT = st_q.preset_stored;
  assign FACTORY_HOME_FLAG_OUT = st_q.factory_home;

endmodule

`default_nettype wire

// *** verif/posind_top_props.sv ***
// Checker for the position indication outputs, bound to the top module
`timescale 1ns/1ns
`default_nettype none

module posind_top_props (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  // Inputs watched
  input wire logic [31:0] CMD_POS_IN,
  input wire logic REVOLUTION_MARKER_PRESET_CMD_IN,
  input wire logic WRAP_EN_IN,
  input wire logic SOFT_OT_EN_IN,
  input wire logic [31:0] FWD_SOFT_LIMIT_IN,
  input wire logic [31:0] REV_SOFT_LIMIT_IN,
  input wire logic PRESET_DONE_IN,
  input wire logic HOMING_DONE_IN,
  input wire logic RES_CHANGE_IN,
  input wire logic SENSOR_SAVED_IN,
  input wire logic [31:0] PRESET_POS_IN,
  // Outputs watched
  input wire logic REVOLUTION_MARKER_OUT,
  input wire logic WRAP_ZERO_PULSE_OUT,
  input wire logic WRAP_OVERFLOW_TOGGLE_OUT,
  input wire logic FORWARD_SOFT_LIMIT_FLAG_OUT,
  input wire logic REVERSE_SOFT_LIMIT_FLAG_OUT,
  input wire logic COORDINATES_VALID_FLAG_OUT,
  input wire logic HOME_INVALID_FLAG_OUT,
  input wire logic PRESET_STORED_FLAG_OUT,
  input wire logic FACTORY_HOME_FLAG_OUT
);
  // ==========================================================
  // Home and preset history since reset
  logic home_ever_q;
  logic preset_ever_q;

  // Sticky event history
  always_ff @(posedge CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      home_ever_q <= 1'b0;
      preset_ever_q <= 1'b0;
    end
    else
    begin
      home_ever_q <= home_ever_q | PRESET_DONE_IN | HOMING_DONE_IN | FACTORY_HOME_FLAG_OUT;
      preset_ever_q <= preset_ever_q | PRESET_DONE_IN;
    end
  end

  // ==========================================================
  // Properties, one clock domain
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  property p_fw_limit;
    1'b1 |=> FORWARD_SOFT_LIMIT_FLAG_OUT
      == $past(SOFT_OT_EN_IN && ($signed(CMD_POS_IN) > $signed(FWD_SOFT_LIMIT_IN)));
  endproperty
  a_fw_limit: assert property (p_fw_limit) else $error("forward limit flag wrong");

  property p_rv_limit;
    ##1 REVERSE_SOFT_LIMIT_FLAG_OUT
      == $past(SOFT_OT_EN_IN && ($signed(CMD_POS_IN) < $signed(REV_SOFT_LIMIT_IN)));
  endproperty
  a_rv_limit: assert property (p_rv_limit) else $error("reverse limit flag wrong");

  property p_marker_preset;
    REVOLUTION_MARKER_PRESET_CMD_IN && !$past(SYS_RST_IN) |=> REVOLUTION_MARKER_OUT;
  endproperty
  a_marker_preset: assert property (p_marker_preset) else $error("no marker at preset");

  property p_zero_off;
    !WRAP_EN_IN |=> !WRAP_ZERO_PULSE_OUT;
  endproperty
  a_zero_off: assert property (p_zero_off) else $error("zero pulse while disabled");

  property p_ovf_hold;
    !WRAP_EN_IN |=> $stable(WRAP_OVERFLOW_TOGGLE_OUT);
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow moved while off");

  property p_inval;
    RES_CHANGE_IN && PRESET_POS_IN != 32'h0 && home_ever_q && !PRESET_DONE_IN
      && !HOMING_DONE_IN && !SENSOR_SAVED_IN
      |=> HOME_INVALID_FLAG_OUT && !COORDINATES_VALID_FLAG_OUT && !PRESET_STORED_FLAG_OUT;
  endproperty
  a_inval: assert property (p_inval) else $error("home loss not flagged");

  property p_auto;
    RES_CHANGE_IN && PRESET_POS_IN == 32'h0 && !PRESET_DONE_IN && !HOMING_DONE_IN
      |=> COORDINATES_VALID_FLAG_OUT && $stable(HOME_INVALID_FLAG_OUT);
  endproperty
  a_auto: assert property (p_auto) else $error("zero preset did not restore");

  property p_home;
    (PRESET_DONE_IN || HOMING_DONE_IN) && !RES_CHANGE_IN
      |=> COORDINATES_VALID_FLAG_OUT && !HOME_INVALID_FLAG_OUT;
  endproperty
  a_home: assert property (p_home) else $error("home event not taken");

  property p_stored;
    SENSOR_SAVED_IN && (preset_ever_q || PRESET_DONE_IN) |=> PRESET_STORED_FLAG_OUT;
  endproperty
  a_stored: assert property (p_stored) else $error("preset stored not shown");
endmodule

bind posind_top posind_top_props posind_top_props_inst (
  .CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .CMD_POS_IN(CMD_POS_IN),
  .REVOLUTION_MARKER_PRESET_CMD_IN(REVOLUTION_MARKER_PRESET_CMD_IN),
  .WRAP_EN_IN(WRAP_EN_IN), .SOFT_OT_EN_IN(SOFT_OT_EN_IN),
  .FWD_SOFT_LIMIT_IN(FWD_SOFT_LIMIT_IN), .REV_SOFT_LIMIT_IN(REV_SOFT_LIMIT_IN),
  .PRESET_DONE_IN(PRESET_DONE_IN), .HOMING_DONE_IN(HOMING_DONE_IN),
  .RES_CHANGE_IN(RES_CHANGE_IN), .SENSOR_SAVED_IN(SENSOR_SAVED_IN),
  .PRESET_POS_IN(PRESET_POS_IN), .REVOLUTION_MARKER_OUT(REVOLUTION_MARKER_OUT),
  .WRAP_ZERO_PULSE_OUT(WRAP_ZERO_PULSE_OUT), .WRAP_OVERFLOW_TOGGLE_OUT(WRAP_OVERFLOW_TOGGLE_OUT),
  .FORWARD_SOFT_LIMIT_FLAG_OUT(FORWARD_SOFT_LIMIT_FLAG_OUT),
  .REVERSE_SOFT_LIMIT_FLAG_OUT(REVERSE_SOFT_LIMIT_FLAG_OUT),
  .COORDINATES_VALID_FLAG_OUT(COORDINATES_VALID_FLAG_OUT),
  .HOME_INVALID_FLAG_OUT(HOME_INVALID_FLAG_OUT), .PRESET_STORED_FLAG_OUT(PRESET_STORED_FLAG_OUT),
  .FACTORY_HOME_FLAG_OUT(FACTORY_HOME_FLAG_OUT));

`default_nettype wire

// *** verif/posind_host_model.sv ***
// Host controller model that re-homes the drive once home is lost
`timescale 1ns/1ns
`default_nettype none

module posind_host_model (
  // Clock and status from the drive
  input wire logic clk_in,
  input wire logic home_invalid_in,
  // Re-home delay in cycles
  input wire logic [3:0] delay_in,
  // Re-home done pulse
  output logic homing_done_out
);
  // ==========================================================
  // Cycles seen with home lost
  int wait_cnt = 0;

  // Re-home after the delay; a slow host leaves the flag up
  always @(negedge clk_in)
  begin
    homing_done_out <= 1'b0;
    if (home_invalid_in !== 1'b1)
      wait_cnt <= 0;
    else if (wait_cnt == int'(delay_in))
    begin
      homing_done_out <= 1'b1;
      wait_cnt <= wait_cnt + 1;
    end
    else if (wait_cnt < int'(delay_in))
      wait_cnt <= wait_cnt + 1;
  end
endmodule

`default_nettype wire

// *** verif/posind_top_tb.sv ***
// Self-checking bench for the position indication outputs
`timescale 1ns/1ns
`default_nettype none

module posind_top_tb;
  // ==========================================================
  // Stimulus, outputs and counters
  logic clk = 1'b0;
  logic rst, mpre, wen, wsrc, soen, pdone, hdone, rchg, ssav, strap;
  logic [31:0] fb, cmd, tgt, res, wrng, fwl, rvl, ppos;
  logic [10:0] mw;
  logic [28:0] wdiv;
  logic [13:0] wwid;
  logic [7:0][31:0] apb, anb;
  logic [7:0] amode, asrc, af;
  logic [3:0] hdly;
  logic mk, wz, wo, fwf, rvf, cv, hi, ps, fh;
  int n_mismatch = 0;
  int tests_run = 0;

  // 250 MHz clock
  initial forever #2 clk = ~clk;

  posind_top posind_top_inst (
    .CLK_IN(clk), .SYS_RST_IN(rst), .FB_POS_IN(fb), .CMD_POS_IN(cmd), .TARGET_POS_IN(tgt),
    .RES_STEPS_IN(res), .REVOLUTION_MARKER_PRESET_CMD_IN(mpre), .MARKER_WIDTH_IN(mw),
    .WRAP_EN_IN(wen), .WRAP_RANGE_IN(wrng), .WRAP_ZERO_DIV_IN(wdiv), .WRAP_ZERO_WIDTH_IN(wwid),
    .WRAP_ZERO_SRC_IN(wsrc), .AREA_POS_BOUND_IN(apb), .AREA_NEG_BOUND_IN(anb),
    .AREA_MODE_IN(amode), .AREA_SRC_IN(asrc), .SOFT_OT_EN_IN(soen), .FWD_SOFT_LIMIT_IN(fwl),
    .REV_SOFT_LIMIT_IN(rvl), .PRESET_DONE_IN(pdone), .HOMING_DONE_IN(hdone),
    .RES_CHANGE_IN(rchg), .SENSOR_SAVED_IN(ssav), .PRESET_POS_IN(ppos),
    .FACTORY_HOME_STRAP_IN(strap), .REVOLUTION_MARKER_OUT(mk), .WRAP_ZERO_PULSE_OUT(wz),
    .WRAP_OVERFLOW_TOGGLE_OUT(wo), .AREA_FLAG_OUT(af), .FORWARD_SOFT_LIMIT_FLAG_OUT(fwf),
    .REVERSE_SOFT_LIMIT_FLAG_OUT(rvf), .COORDINATES_VALID_FLAG_OUT(cv),
    .HOME_INVALID_FLAG_OUT(hi), .PRESET_STORED_FLAG_OUT(ps), .FACTORY_HOME_FLAG_OUT(fh));

  // Host model
  posind_host_model posind_host_model_inst (
    .clk_in(clk), .home_invalid_in(hi), .delay_in(hdly), .homing_done_out(hdone));

  // ==========================================================
  // Compare and report
  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("counts: %0d compares, %0d mismatches", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Window judgement in 64 bits
  function automatic logic hit(input logic [31:0] p, n, input logic m, input logic [31:0] x, t);
    longint sp, sn, sx, c;
    sp = longint'($signed(p));
    sn = longint'($signed(n));
    sx = longint'($signed(x));
    c = longint'($signed(t)) + sp;
    if (m)
      return (sx >= c - sn) && (sx <= c + sn);
    if (sp > sn)
      return (sx >= sn) && (sx <= sp);
    if (sp < sn)
      return (sx <= sp) || (sx >= sn);
    return sx == sp;
  endfunction

  // Full-range or small values, so bounds meet often
  function automatic logic [31:0] rnd(input int i);
    return (i % 2 == 1) ? 32'($urandom_range(0, 40)) - 32'h14 : 32'($urandom);
  endfunction

  // ==========================================================
  // Reset with inputs at rest, positions at zero and the strap as given
  task automatic do_reset(input logic s = 1'b0);
    rst = 1'b1;
    strap = s;
    {fb, cmd, tgt, ppos, mpre, wen, wsrc, soen, pdone, rchg, ssav} = '0;
    {res, wrng, fwl, rvl} = {32'h00000168, 32'h00000064, 32'h7fffffff, 32'h80000000};
    {mw, wdiv, wwid} = {11'h012, 29'h00000004, 14'h0003};
    {apb, anb, amode, asrc} = '0;
    repeat (2) @(negedge clk);
    check({mk, wz, wo, af, fwf, rvf, cv, hi, ps, fh}, 17'h00000);
    rst = 1'b0;
  endtask

  // Areas and limits, random; equal bounds every fourth pass
  task automatic t_area();
    logic [9:0] e;
    do_reset();
    for (int i = 0; i < 300; i++)
    begin
      {fb, cmd, tgt, fwl, rvl} = {rnd(i), rnd(i), rnd(i), rnd(i), rnd(i)};
      soen = $urandom_range(0, 3) != 0;
      {amode, asrc} = 16'($urandom);
      for (int k = 0; k < 8; k++)
      begin
        apb[k] = rnd(i);
        anb[k] = (i % 4 == 0) ? apb[k] : rnd(i);
      end
      if (i % 3 == 1)
        {fb, cmd} = {anb[i % 8], apb[(i + 1) % 8]};
      @(negedge clk);
      for (int k = 0; k < 8; k++)
        e[k] = hit(apb[k], anb[k], amode[k], asrc[k] ? cmd : fb, tgt);
      e[8] = soen && ($signed(cmd) > $signed(fwl));
      e[9] = soen && ($signed(cmd) < $signed(rvl));
      check(17'(af), 17'(e[7:0]));
      check(17'({rvf, fwf}), 17'(e[9:8]));
    end
  endtask

  // Marker over several turns: 50 tenths of a 360-step turn is 5 steps
  task automatic t_marker();
    do_reset();
    mw = 11'h032;
    fb = 32'h00000064;
    repeat (3) @(negedge clk);
    mpre = 1'b1;
    @(negedge clk);
    mpre = 1'b0;
    for (int i = 0; i < 400; i++)
    begin
      check(17'(mk), 17'(((fb - 32'h64) % 32'h168) < 32'h5));
      fb = fb + 32'h3;
      @(negedge clk);
    end
  endtask

  // Wrap of 100 steps in 4 intervals, 3-step pulse; other source wanders
  task automatic t_wrap(input logic s);
    do_reset();
    {wen, wsrc} = {1'b1, s};
    for (int x = 0; x < 260; x++)
    begin
      if (s)
        {cmd, fb} = {32'(x), 32'($urandom_range(0, 9))};
      else
        {fb, cmd} = {32'(x), 32'($urandom_range(0, 9))};
      @(negedge clk);
      check(17'({wo, wz}), 17'({x / 100 % 2 == 1, x % 25 < 3}));
    end
    wen = 1'b0;
    @(negedge clk);
    check(17'(wz), 17'h00000);
  endtask

  // One cycle of events, then the coordinate flags
  task automatic ev(input logic [2:0] e, input logic [31:0] pp, input logic [3:0] x);
    {pdone, ssav, rchg} = e;
    ppos = pp;
    @(negedge clk);
    {pdone, ssav, rchg} = '0;
    check(17'({cv, hi, ps, fh}), 17'(x));
  endtask

  // Home bookkeeping through loss, re-home, automatic restore and strap
  task automatic t_coord();
    do_reset();
    hdly = 4'($urandom_range(0, 9));
    ev(3'b001, 32'h5, 4'b0000);
    ev(3'b100, 32'h5, 4'b1000);
    ev(3'b010, 32'h5, 4'b1010);
    ev(3'b001, 32'h5, 4'b0100);
    for (int i = 0; i < 40 && hi !== 1'b0; i++)
      @(negedge clk);
    check(17'({cv, hi, ps, fh}), 17'h00008);
    ev(3'b001, 32'h0, 4'b1000);
    do_reset(1'b1);
    repeat (5) @(negedge clk);
    check(17'({cv, fh}), 17'h00003);
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    hdly = 4'h0;
    void'($urandom(32'hc0503cd1));
    t_area();
    $display("test area done");
    t_marker();
    $display("test marker done");
    t_wrap(1'b0);
    t_wrap(1'b1);
    $display("test wrap done");
    t_coord();
    $display("test coordinates done");
    results();
  end

  // Watchdog, far beyond the 1300 or so cycles needed
  initial
  begin
    #40000;
    n_mismatch++;
    results();
  end
endmodule

`default_nettype wire
